// [bench/pccsc_card_model.sv]
// Card model for one slot: detect, battery or speaker and request lines.
// Assumes the bench calls its tasks just after a rising core_clk edge.
`timescale 1ns/100ps
module pccsc_card_model
  import pccsc_pkg::*;
(
  output pccsc_pkg::pccsc_pins_s card_pins
);
  import pccsc_pkg::*;

  logic cd2;
  logic cd1;
  logic rdy;
  logic b2;
  logic b1;

  // ==========================================================
  // Pin drive
  // Empty socket: pull-ups win on every line, so no stale level shows
  assign card_pins = (cd1 & cd2) ? '1 : {rdy, cd2, cd1, b2, b1};

  initial
  begin
    cd2 = 1'b1;
    cd1 = 1'b1;
    rdy = 1'b1;
    b2  = 1'b1;
    b1  = 1'b1;
  end

  // Detect pins are low while seated
  task automatic plug(input logic c2, input logic c1);
    cd2 <= c2;
    cd1 <= c1;
  endtask : plug

  // Request or ready, battery two or speaker, battery one or status change
  task automatic lines(input logic r, input logic v2, input logic v1);
    rdy <= r;
    b2  <= v2;
    b1  <= v1;
  endtask : lines
endmodule : pccsc_card_model

// [bench/test_pc_card_area_status_control.sv]
// Testbench for the card slot block: register and pin tests over AHB-Lite.
// Assumes zero wait-state slave and a card model on the slot pins.
`timescale 1ns/100ps
module test_pc_card_area_status_control;
  import pccsc_pkg::*;

  logic        core_clk;
  logic        nrst;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        acc_io;
  logic        acc_addr24;
  logic        acc_addr25;
  logic        hresp;
  logic        rsp;
  logic        buf_n;
  logic        rst_pin;
  logic        reg_sel;
  logic        a24;
  logic        a25;
  logic        irq;
  logic        com;
  logic        use_b;
  logic [3:0]  kv;
  pccsc_pins_s pins;
  int          error_cnt;
  int          n_checks;

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  pccsc_card_model i_card (.card_pins(pins));

  pccsc_slot i_dut (
    .core_clk(core_clk), .nrst(nrst), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .card_pins(pins), .acc_io(acc_io), .acc_addr24(acc_addr24), .acc_addr25(acc_addr25),
    .buffer_control_pin_n(buf_n), .card_reset_pin(rst_pin),
    .register_select_pin(reg_sel), .card_a24(a24), .card_a25(a25), .slot_irq(irq)
  );

  // ==========================================================
  // Report and compare
  task automatic print_verdict();
    $display("Checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic check_word(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : check_word

  task automatic check_pin(input string what, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask : check_pin

  // ==========================================================
  // Bus cycles
  // Bounded wait for hready at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge core_clk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        error_cnt++;
        $display("ERROR hready expected 1 seen %b", hreadyout);
        print_verdict();
      end
      @(posedge core_clk);
    end
  endtask : wait_ready

  task automatic bus(input logic wr_en, input logic [7:0] ofs, input logic [7:0] wd);
    haddr  <= {24'h0, ofs};
    hwrite <= wr_en;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wait_ready();
    rd = hrdata;
    rsp = hresp;
  endtask : bus

  // software keeps reserved flag bit 6 at zero
  task automatic wr(input logic [7:0] ofs, input logic [7:0] wd);
    bus(1'b1, ofs, (ofs == OFS_FLAGS) ? (wd & 8'hbf) : wd);
  endtask : wr

  task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] e);
    bus(1'b0, ofs, 8'h00);
    check_word("register", {24'h0, e}, rd);
    check_pin("hresp", 1'b0, rsp);
  endtask : rd_chk

  task automatic pause(input int n);
    repeat (n) @(posedge core_clk);
  endtask : pause

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    $display("ERROR run length expected finish seen timeout");
    print_verdict();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    error_cnt = 0;
    n_checks = 0;
    nrst = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    acc_io = 1'b0;
    acc_addr24 = 1'b0;
    acc_addr25 = 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rd_chk(OFS_CONTROL, 8'h00);
    rd_chk(OFS_FLAGS, 8'h00);
    check_pin("buffer pin", 1'b1, buf_n);
    check_pin("reset pin", 1'b0, rst_pin);
    // Controller enabled, otherwise card events are ignored
    wr(OFS_CONTROL, 8'hd0);
    pause(2);
    check_pin("buffer pin", 1'b0, buf_n);
    check_pin("reset pin", 1'b1, rst_pin);
    rd_chk(OFS_CONTROL, 8'hd0);
    // Insertion, then the battery states in memory-card mode
    i_card.plug(1'b0, 1'b0);
    pause(4);
    rd_chk(OFS_FLAGS, 8'h08);
    wr(OFS_FLAGS, 8'h08);
    rd_chk(OFS_FLAGS, 8'h08);
    wr(OFS_FLAGS, 8'h00);
    rd_chk(OFS_FLAGS, 8'h00);
    for (int i = 3; i >= 0; i--)
    begin
      i_card.lines(1'b1, i[1], i[0]);
      pause(4);
      rd_chk(OFS_STATUS, {6'h20, i[1:0]});
    end
    rd_chk(OFS_FLAGS, 8'h00);
    i_card.plug(1'b0, 1'b1);
    wr(OFS_STATUS, 8'h00);
    pause(4);
    rd_chk(OFS_STATUS, 8'h84);
    rd_chk(OFS_FLAGS, 8'h08);
    wr(OFS_FLAGS, 8'h00);
    i_card.plug(1'b0, 1'b0);
    // Software detect trigger with and without its enable
    wr(OFS_ENABLE, 8'h08);
    pause(4);
    wr(OFS_FLAGS, 8'h00);
    wr(OFS_FLAGS, 8'h80);
    pause(2);
    check_pin("irq", 1'b1, irq);
    rd_chk(OFS_FLAGS, 8'h80);
    wr(OFS_FLAGS, 8'h00);
    pause(2);
    check_pin("irq", 1'b0, irq);
    wr(OFS_ENABLE, 8'h00);
    wr(OFS_FLAGS, 8'h80);
    pause(2);
    check_pin("irq", 1'b0, irq);
    wr(OFS_FLAGS, 8'h00);
    // Address pins over mode, space, address bits 24 and 25 and space bit
    for (int k = 0; k < 17; k++)
    begin
      kv = k[3:0];
      use_b = (k < 16);
      acc_io <= kv[2];
      acc_addr24 <= kv[1];
      acc_addr25 <= !kv[0];
      wr(OFS_CONTROL, {3'b000, use_b, kv[3], 2'b10, kv[0]});
      pause(2);
      com = !kv[2] && (kv[3] ? kv[1] : kv[0]);
      check_pin("select", use_b & com, reg_sel);
      check_pin("a24", use_b & !(kv[3] & com) & kv[1], a24);
      check_pin("a25", use_b & (com | !kv[0]), a25);
    end
    // I/O-card mode: speaker, status change and request modes
    i_card.lines(1'b1, 1'b1, 1'b1);
    wr(OFS_CONTROL, 8'h30);
    pause(4);
    rd_chk(OFS_STATUS, 8'h83);
    i_card.lines(1'b1, 1'b1, 1'b0);
    pause(4);
    rd_chk(OFS_FLAGS, 8'h10);
    wr(OFS_FLAGS, 8'h10);
    rd_chk(OFS_FLAGS, 8'h10);
    wr(OFS_ENABLE, 8'h10);
    pause(2);
    check_pin("irq", 1'b1, irq);
    wr(OFS_FLAGS, 8'h00);
    rd_chk(OFS_FLAGS, 8'h00);
    check_pin("irq", 1'b0, irq);
    wr(OFS_ENABLE, 8'h20);
    i_card.lines(1'b0, 1'b1, 1'b0);
    pause(4);
    rd_chk(OFS_FLAGS, 8'h20);
    check_pin("irq", 1'b1, irq);
    i_card.lines(1'b1, 1'b1, 1'b0);
    pause(4);
    rd_chk(OFS_FLAGS, 8'h00);
    wr(OFS_ENABLE, 8'h40);
    i_card.lines(1'b0, 1'b1, 1'b0);
    pause(4);
    rd_chk(OFS_FLAGS, 8'h20);
    wr(OFS_FLAGS, 8'h20);
    rd_chk(OFS_FLAGS, 8'h20);
    wr(OFS_FLAGS, 8'h00);
    rd_chk(OFS_FLAGS, 8'h00);
    i_card.lines(1'b1, 1'b1, 1'b0);
    pause(4);
    i_card.lines(1'b0, 1'b1, 1'b0);
    pause(4);
    wr(OFS_ENABLE, 8'h60);
    rd_chk(OFS_FLAGS, 8'h00);
    i_card.lines(1'b1, 1'b1, 1'b0);
    pause(4);
    rd_chk(OFS_FLAGS, 8'h20);
    print_verdict();
  end
endmodule : test_pc_card_area_status_control

// [rtl/pccsc_pin_sync.sv]
// Two-stage synchroniser for the card's status pins.
// Assumes the pins are asynchronous to core_clk.
`timescale 1ns/100ps
module pccsc_pin_sync
  import pccsc_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               nrst,
  input  wire logic               ce,
  input  wire pccsc_pkg::pccsc_pins_s pins_in,
  output pccsc_pkg::pccsc_pins_s  pins_out
);

  pccsc_sync_state_s st;
  pccsc_sync_state_s next_st;

  // ==========================================================
  // Next state: first stage feeds only the second
  always_comb
  begin
    next_st        = st;
    next_st.meta   = pins_in;
    next_st.stable = st.meta;
    if (!ce)
    begin
      next_st = st;
    end
  end

  // Register the state
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // Pulled-up idle level, so no false edge appears after reset
      st <= '1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign pins_out = st.stable;

endmodule : pccsc_pin_sync

// [rtl/pccsc_pkg.sv]
// Constants, types and state records for the card slot status block.
// Assumes a single 10 MHz bus clock and an AHB-Lite register port.
package pccsc_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_FLAGS   = 8'h08;
  localparam logic [7:0] OFS_ENABLE  = 8'h0c;

  // ==========================================================
  // Field positions
  localparam int CTL_BUF  = 7;
  localparam int CTL_RST  = 6;
  localparam int CTL_TYPE = 5;
  localparam int CTL_USE  = 4;
  localparam int CTL_MODE = 3;
  localparam int CTL_A25  = 2;
  localparam int CTL_A24  = 1;
  localparam int CTL_REG  = 0;
  localparam int FLG_SDI  = 7;
  localparam int FLG_IREQ = 5;
  localparam int FLG_SC   = 4;
  localparam int FLG_CDC  = 3;
  localparam int IEN_CRE  = 7;
  localparam int IEN_MH   = 6;
  localparam int IEN_ML   = 5;
  localparam int IEN_SCE  = 4;
  localparam int IEN_CDE  = 3;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] IEN_RESET   = 8'h00;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {MODE_OFF, MODE_LEVEL, MODE_FALL, MODE_RISE} pccsc_irq_mode_e;

  typedef struct packed {
    logic ready_irq_level;
    logic card_detect_two_level;
    logic card_detect_one_level;
    logic battery_sense_two_level;
    logic battery_sense_one_level;
  } pccsc_pins_s;

  typedef struct packed {
    pccsc_pins_s meta;
    pccsc_pins_s stable;
  } pccsc_sync_state_s;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  ien;
    logic        sdi;
    logic        ireq;
    logic        sc;
    logic        cdc;
    pccsc_pins_s prev;
    logic        primed;
    logic        dp_wr;
    logic [7:0]  dp_addr;
    logic        ready;
    logic        resp;
    logic [31:0] rdata;
    logic        buf_n;
    logic        rst_pin;
    logic        reg_sel;
    logic        a24;
    logic        a25;
    logic        irq;
  } pccsc_state_s;

endpackage : pccsc_pkg

// [rtl/pccsc_slot.sv]
// Card slot status, control and status-change logic with AHB-Lite registers.
// Assumes one bus master, word accesses, card pins asynchronous to core_clk,
// and access qualifiers (acc_*) from logic on the same clock.
`timescale 1ns/100ps
module pccsc_slot
  import pccsc_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  input  wire pccsc_pkg::pccsc_pins_s card_pins,
  input  wire logic                   acc_io,
  input  wire logic                   acc_addr24,
  input  wire logic                   acc_addr25,
  output logic                        buffer_control_pin_n,
  output logic                        card_reset_pin,
  output logic                        register_select_pin,
  output logic                        card_a24,
  output logic                        card_a25,
  output logic                        slot_irq
);

  // ==========================================================
  // Decoders shared by the state logic and the checks
  function automatic pccsc_irq_mode_e decode_mode(input logic [1:0] bits);
    pccsc_irq_mode_e m;
    m = MODE_OFF;
    unique case (bits)
      2'h0: m = MODE_OFF;
      2'h1: m = MODE_LEVEL;
      2'h2: m = MODE_FALL;
      2'h3: m = MODE_RISE;
    endcase
    return m;
  endfunction : decode_mode

  // Common memory: not I/O; space bit in wide mode, address in narrow
  function automatic logic is_common(input logic narrow, input logic io,
                                     input logic a24, input logic regbit);
    return !io && (narrow ? a24 : regbit);
  endfunction : is_common

  // ==========================================================
  // Declarations
  pccsc_state_s    st;
  pccsc_state_s    next_st;
  pccsc_pins_s     syn;
  pccsc_irq_mode_e mode_cur;
  logic            io_card;
  logic            active;
  logic            wr_ctrl;
  logic            wr_flags;
  logic            wr_ien;
  logic            cd_change;
  logic            sc_fall;
  logic            ireq_edge;
  logic            ireq_set;
  logic            ireq_view;
  logic            pulse_mode;
  logic            narrow;
  logic            common;
  logic            accept;
  logic            speaker_level;
  logic            status_change_level;
  logic [7:0]      rd_byte;

  // Card pins pass two flops before use
  pccsc_pin_sync u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .ce       (ce),
    .pins_in  (card_pins),
    .pins_out (syn)
  );

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    next_st             = st;
    io_card             = st.ctrl[CTL_TYPE];
    active              = st.ctrl[CTL_USE] && st.primed;
    mode_cur            = decode_mode(st.ien[IEN_MH:IEN_ML]);
    pulse_mode          = (mode_cur == MODE_FALL) || (mode_cur == MODE_RISE);
    narrow              = st.ctrl[CTL_MODE];
    common              = is_common(narrow, acc_io, acc_addr24, st.ctrl[CTL_REG]);
    speaker_level       = syn.battery_sense_two_level;
    status_change_level = syn.battery_sense_one_level;
    wr_ctrl             = st.dp_wr && (st.dp_addr == OFS_CONTROL);
    wr_flags            = st.dp_wr && (st.dp_addr == OFS_FLAGS);
    wr_ien              = st.dp_wr && (st.dp_addr == OFS_ENABLE);
    cd_change = (syn.card_detect_one_level != st.prev.card_detect_one_level) ||
                (syn.card_detect_two_level != st.prev.card_detect_two_level);
    sc_fall   = io_card && st.prev.battery_sense_one_level && !status_change_level;
    unique case (mode_cur)
      MODE_FALL: ireq_edge = st.prev.ready_irq_level && !syn.ready_irq_level;
      MODE_RISE: ireq_edge = !st.prev.ready_irq_level && syn.ready_irq_level;
      MODE_OFF, MODE_LEVEL: ireq_edge = 1'b0;
    endcase
    // request flag set only in I/O mode
    ireq_set  = active && io_card && ireq_edge;
    // level and off modes show the pin inverted
    if (!io_card)
    begin
      ireq_view = 1'b0;
    end
    else if (pulse_mode)
    begin
      ireq_view = st.ireq;
    end
    else
    begin
      ireq_view = !syn.ready_irq_level;
    end

    // control written by software, kept otherwise except on reset-enabled insertion
    if (wr_ctrl)
    begin
      next_st.ctrl = hwdata[7:0];
    end
    // Card insertion with reset-enable set restores control defaults
    if (active && st.ien[IEN_CRE] && cd_change &&
        !syn.card_detect_one_level && !syn.card_detect_two_level)
    begin
      next_st.ctrl = CTRL_RESET;
    end
    if (wr_ien)
    begin
      next_st.ien = hwdata[7:0];
    end

    // software sets only bit 7; others clear on zero, request only in pulse mode
    if (wr_flags)
    begin
      next_st.sdi = hwdata[FLG_SDI];
      // zero clears detect change, one ignored
      if (!hwdata[FLG_CDC])
      begin
        next_st.cdc = 1'b0;
      end
      if (!hwdata[FLG_SC])
      begin
        next_st.sc = 1'b0;
      end
      // zero clears request only in pulse mode
      if (!hwdata[FLG_IREQ] && pulse_mode)
      begin
        next_st.ireq = 1'b0;
      end
    end
    // mode change drops the request flag
    if (wr_ien && (hwdata[IEN_MH:IEN_ML] != st.ien[IEN_MH:IEN_ML]))
    begin
      next_st.ireq = 1'b0;
    end

    // Hardware sets win over any clear in the same cycle
    // detect pin change sets flag
    if (active && cd_change)
    begin
      next_st.cdc = 1'b1;
    end
    if (active && sc_fall)
    begin
      next_st.sc = 1'b1;
    end
    if (ireq_set)
    begin
      next_st.ireq = 1'b1;
    end
    // Priming avoids a false detect change right after reset
    next_st.prev   = syn;
    next_st.primed = 1'b1;

    // ==========================================================
    // Bus slave: zero wait states, always OKAY
    accept          = hsel && htrans[1] && hready;
    next_st.dp_wr   = accept && hwrite;
    next_st.dp_addr = haddr[7:0];
    next_st.ready   = 1'b1;
    next_st.resp    = 1'b0;
    rd_byte         = 8'h00;
    unique case (haddr[7:0])
      OFS_STATUS:
      begin
        rd_byte[2] = syn.card_detect_one_level;
        rd_byte[3] = syn.card_detect_two_level;
        rd_byte[7] = syn.ready_irq_level;
        // pair 11 good, 01 warning, x0 dead, read as-is
        rd_byte[1] = io_card ? speaker_level : syn.battery_sense_two_level;
        rd_byte[0] = io_card ? status_change_level : syn.battery_sense_one_level;
      end
      OFS_CONTROL: rd_byte = st.ctrl;
      OFS_FLAGS:
      begin
        rd_byte[FLG_SDI]  = st.sdi;
        rd_byte[FLG_IREQ] = ireq_view;
        rd_byte[FLG_SC]   = io_card && st.sc;
        rd_byte[FLG_CDC]  = st.cdc;
      end
      OFS_ENABLE: rd_byte = st.ien;
      default: rd_byte = 8'h00;
    endcase
    next_st.rdata = (accept && !hwrite) ? {24'h000000, rd_byte} : 32'h00000000;

    // ==========================================================
    // Card pins
    // buffer pin low when bit set
    next_st.buf_n   = !st.ctrl[CTL_BUF];
    next_st.rst_pin = st.ctrl[CTL_RST];
    if (!st.ctrl[CTL_USE])
    begin
      next_st.reg_sel = 1'b0;
      next_st.a24     = 1'b0;
      next_st.a25     = 1'b0;
    end
    else
    begin
      // space bit only in wide mode
      // wide mode select from space bit
      // narrow mode: common high, others low
      next_st.reg_sel = acc_io ? 1'b0 : (narrow ? acc_addr24 : st.ctrl[CTL_REG]);
      next_st.a24 = (narrow && common) ? st.ctrl[CTL_A24] : acc_addr24;
      next_st.a25 = common ? st.ctrl[CTL_A25] : acc_addr25;
    end

    // interrupt while an enabled flag is set
    // soft detect shares the detect enable
    next_st.irq = ((next_st.sdi || next_st.cdc) && next_st.ien[IEN_CDE]) ||
                  (io_card && next_st.sc && next_st.ien[IEN_SCE]) ||
                  (io_card && pulse_mode && next_st.ireq) ||
                  (io_card && (mode_cur == MODE_LEVEL) && !syn.ready_irq_level);

    // Clock enable freezes everything
    if (!ce)
    begin
      next_st = st;
    end
  end

  // ==========================================================
  // State register
  // flags cleared by reset and by software writes
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st         <= '0;
      // Edge history starts at the pins' idle level, matching the synchroniser
      st.prev    <= '1;
      st.ctrl    <= CTRL_RESET;
      st.ien     <= IEN_RESET;
      st.ready   <= 1'b1;
      st.buf_n   <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign hreadyout            = st.ready;
  assign hresp                = st.resp;
  assign hrdata               = st.rdata;
  assign buffer_control_pin_n = st.buf_n;
  assign card_reset_pin       = st.rst_pin;
  assign register_select_pin  = st.reg_sel;
  assign card_a24             = st.a24;
  assign card_a25             = st.a25;
  assign slot_irq             = st.irq;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_buffer_level: assert property (ce |=> buffer_control_pin_n != $past(st.ctrl[CTL_BUF]))
    else $error("buffer pin does not follow control bit 7");
  a_reset_level: assert property (ce |=> card_reset_pin == $past(st.ctrl[CTL_RST]))
    else $error("card reset pin does not follow control bit 6");
  a_io_select_low: assert property (ce && acc_io |=> !register_select_pin)
    else $error("select pin high during I/O access");
  a_wide_select: assert property (ce && st.ctrl[CTL_USE] && !narrow && !acc_io
                   |=> register_select_pin == $past(st.ctrl[CTL_REG]))
    else $error("wide mode select does not follow space bit");
  a_a25_common: assert property (ce && st.ctrl[CTL_USE] && common
                  |=> card_a25 == $past(st.ctrl[CTL_A25]))
    else $error("A25 does not follow bit 2 on common access");
  a_reserved_zero: assert property (ce && accept && !hwrite && haddr[7:0] == OFS_FLAGS
                     |=> !hrdata[6] && hrdata[31:8] == 24'h000000)
    else $error("reserved flag bit read nonzero");
  a_mem_flags_zero: assert property (ce && accept && !hwrite && haddr[7:0] == OFS_FLAGS
                      && !io_card |=> hrdata[FLG_IREQ:FLG_SC] == 2'h0)
    else $error("I/O flags nonzero in memory mode");
  a_detect_set: assert property (ce && active && cd_change |=> st.cdc)
    else $error("detect change not latched");
  a_detect_hold: assert property (ce && st.cdc && !(wr_flags && !hwdata[FLG_CDC])
                   |=> st.cdc)
    else $error("detect change flag lost without zero write");
  a_soft_irq: assert property (ce && st.sdi && st.ien[IEN_CDE] && !st.dp_wr
                |=> slot_irq)
    else $error("soft detect change gave no interrupt");
  a_mode_clear: assert property (ce && wr_ien && !ireq_set &&
                  hwdata[IEN_MH:IEN_ML] != st.ien[IEN_MH:IEN_ML] |=> !st.ireq)
    else $error("request flag kept across mode change");

endmodule : pccsc_slot
